// >>> dmwtc_cache.sv
// How it works
// R1: Address splits into 9-bit label, 12-bit index, 1-bit byte select; one word per entry.
// R2: The index picks exactly one of 4096 entries for every access.
// R3: Entry holds tag, tag parity, valid, two data bytes and two byte parities.
// R4: Hit needs tag equal to label, valid set, and no parity error.
// R5: Read hit returns the stored bytes without touching memory.
// R6: Read miss fetches the word from main memory.
// R7: Allocation writes label, sets valid, loads both bytes, writes correct parity unless a wrong-parity diagnostic bit is set.
// R8: Allocate only on read miss and word write miss.
// R9: Every write goes to memory; write hit also updates the cached bytes.
// R10: Byte write miss updates memory only.
// R11: The top 8 Kb is never cached and always misses.
// R12: After power-up all entries are invalidated with correct parity.
// R13: A DMA write that hits invalidates the entry.
// R14: DMA writes are watched; one address is held pending, and a newer write replaces it.
// R15: Force miss: always memory, parity ignored, no allocation, store unchanged.
// R16: Bypass: memory access, parity checked, hit invalidates, miss leaves store.
// R17: Bypass bit routes all references to memory; read hits invalidate.
// R18: Writing one to the flush bit invalidates everything; zero does nothing.
// R19: Even parity on low byte and tag, odd parity on high byte.
// R20: DMA reads neither allocate nor invalidate.
`timescale 1ns/1ns
`default_nettype none

module dmwtc_cache (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_byte,
  input wire logic [21:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic cpu_ack,
  output logic [15:0] cpu_rdata,
  output logic cpu_hit,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [21:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic dma_valid,
  input wire logic dma_we,
  input wire logic [21:0] dma_addr,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmwtc_pkg::dmwtc_state_e st, next_st;
  logic req_we, next_req_we;
  logic req_byte, next_req_byte;
  logic [21:0] req_addr, next_req_addr;
  logic [15:0] req_wdata, next_req_wdata;
  logic alloc, next_alloc;
  logic next_cpu_ack, next_cpu_hit;
  logic [15:0] next_cpu_rdata;
  logic dma_pend, next_dma_pend;
  logic [21:0] dma_addr_q, next_dma_addr_q;
  logic flush_pend, next_flush_pend;
  logic [11:0] flush_idx, next_flush_idx;
  logic [15:0] cache_control_reg, next_ccr;
  logic last_hit, next_last_hit;
  logic par_err, next_par_err;
  logic [15:0] next_reg_rdata;

  // ----------------------------------------------------------------
  // Store access and entry fields
  // ----------------------------------------------------------------
  logic [11:0] rd_idx, wr_idx;
  logic [28:0] entry, wr_entry;
  logic st_we;
  logic [8:0] e_tag, wr_tag, cmp_label, req_label;
  logic [7:0] e_hi, e_lo, wr_hi, wr_lo;
  logic e_valid, wr_valid;
  logic chk_tp, chk_hp, chk_lp, gen_tp, gen_hp, gen_lp;
  logic par_ok, tag_match, io_page, force_miss, bypass, look_hit, bad_par;
  logic [11:0] req_index, dma_index;

  dmwtc_store u_store (
    .ref_clk(ref_clk),
    .rd_idx(rd_idx),
    .rd_entry(entry),
    .wr_en(st_we),
    .wr_idx(wr_idx),
    .wr_entry(wr_entry)
  );

  assign e_tag = entry[dmwtc_pkg::E_TAG_LSB +: dmwtc_pkg::LABEL_W]; // R3
  assign e_valid = entry[dmwtc_pkg::E_VALID];
  assign e_hi = entry[dmwtc_pkg::E_HI_LSB +: dmwtc_pkg::BYTE_W];
  assign e_lo = entry[dmwtc_pkg::E_LO_LSB +: dmwtc_pkg::BYTE_W];
  assign req_label = req_addr[dmwtc_pkg::A_LABEL_LSB +: dmwtc_pkg::LABEL_W]; // R1
  assign req_index = req_addr[dmwtc_pkg::A_INDEX_LSB +: dmwtc_pkg::INDEX_W]; // R2
  assign dma_index = dma_addr_q[dmwtc_pkg::A_INDEX_LSB +: dmwtc_pkg::INDEX_W];

  // ----------------------------------------------------------------
  // Parity check on read, generation on write
  // ----------------------------------------------------------------
  dmwtc_parity #(.W(9), .ODD(1'b0)) u_chk_tag (.data(e_tag), .par(chk_tp)); // R19
  dmwtc_parity #(.W(8), .ODD(1'b1)) u_chk_hi (.data(e_hi), .par(chk_hp)); // R19
  dmwtc_parity #(.W(8), .ODD(1'b0)) u_chk_lo (.data(e_lo), .par(chk_lp)); // R19
  dmwtc_parity #(.W(9), .ODD(1'b0)) u_gen_tag (.data(wr_tag), .par(gen_tp));
  dmwtc_parity #(.W(8), .ODD(1'b1)) u_gen_hi (.data(wr_hi), .par(gen_hp));
  dmwtc_parity #(.W(8), .ODD(1'b0)) u_gen_lo (.data(wr_lo), .par(gen_lp));

  assign par_ok = (chk_tp == entry[dmwtc_pkg::E_TAG_PAR])
    && (chk_hp == entry[dmwtc_pkg::E_HI_PAR])
    && (chk_lp == entry[dmwtc_pkg::E_LO_PAR]);
  assign cmp_label = (st == dmwtc_pkg::ST_SNOOP)
    ? dma_addr_q[dmwtc_pkg::A_LABEL_LSB +: dmwtc_pkg::LABEL_W] : req_label;
  assign tag_match = (e_tag == cmp_label);
  assign io_page = (req_label == dmwtc_pkg::IO_LABEL); // R11
  assign force_miss = cache_control_reg[dmwtc_pkg::CCR_FORCE_LO] | cache_control_reg[dmwtc_pkg::CCR_FORCE_HI]; // R15
  assign bypass = cache_control_reg[dmwtc_pkg::CCR_BYPASS];
  assign look_hit = tag_match && e_valid && par_ok && !io_page && !force_miss; // R4 R11 R15
  // Parity ignored entirely under force miss
  assign bad_par = e_valid && tag_match && !par_ok && !force_miss;

  // Wrong-parity diagnostics only touch live updates, never invalidations
  assign wr_entry = {wr_tag, gen_tp ^ (wr_valid & cache_control_reg[dmwtc_pkg::CCR_WR_TPAR]), wr_valid,
    wr_hi, gen_hp ^ (wr_valid & cache_control_reg[dmwtc_pkg::CCR_WR_DPAR]),
    wr_lo, gen_lp ^ (wr_valid & cache_control_reg[dmwtc_pkg::CCR_WR_DPAR])}; // R7 R19

  assign mem_req = (st == dmwtc_pkg::ST_MEM);
  assign mem_we = req_we;
  assign mem_byte = req_byte;
  assign mem_addr = req_addr;
  assign mem_wdata = req_wdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_req_we = req_we;
    next_req_byte = req_byte;
    next_req_addr = req_addr;
    next_req_wdata = req_wdata;
    next_alloc = alloc;
    next_cpu_ack = 1'b0;
    next_cpu_hit = cpu_hit;
    next_cpu_rdata = cpu_rdata;
    next_dma_pend = dma_pend;
    next_dma_addr_q = dma_addr_q;
    next_flush_pend = flush_pend;
    next_flush_idx = flush_idx;
    next_ccr = cache_control_reg;
    next_last_hit = last_hit;
    next_par_err = par_err;
    next_reg_rdata = 16'h0000;
    rd_idx = req_index;
    wr_idx = req_index;
    st_we = 1'b0;
    wr_tag = req_label;
    wr_valid = 1'b1;
    wr_hi = e_hi;
    wr_lo = e_lo;

    if (reg_we && reg_addr == dmwtc_pkg::OFS_STAT && reg_wdata[dmwtc_pkg::ST_PAR_ERR])
    begin
      next_par_err = 1'b0;
    end
    if (reg_we && reg_addr == dmwtc_pkg::OFS_CCR)
    begin
      next_ccr = reg_wdata & dmwtc_pkg::CCR_RW_MASK;
    end

    unique case (st)
      dmwtc_pkg::ST_FLUSH:
      begin
        st_we = 1'b1; // R12 R18
        wr_idx = flush_idx;
        wr_tag = 9'h000;
        wr_valid = 1'b0;
        wr_hi = 8'h00;
        wr_lo = 8'h00;
        next_flush_idx = flush_idx + 12'h001;
        if (flush_idx == dmwtc_pkg::FLUSH_LAST)
        begin
          next_st = dmwtc_pkg::ST_IDLE;
        end
      end
      dmwtc_pkg::ST_IDLE:
      begin
        if (dma_pend)
        begin
          rd_idx = dma_index;
          next_dma_pend = 1'b0;
          next_st = dmwtc_pkg::ST_SNOOP;
        end
        else if (flush_pend)
        begin
          next_flush_pend = 1'b0;
          next_flush_idx = 12'h000;
          next_st = dmwtc_pkg::ST_FLUSH;
        end
        else if (cpu_req && !cpu_ack)
        begin
          next_req_we = cpu_we;
          next_req_byte = cpu_byte;
          next_req_addr = cpu_addr;
          next_req_wdata = cpu_wdata;
          rd_idx = cpu_addr[dmwtc_pkg::A_INDEX_LSB +: dmwtc_pkg::INDEX_W]; // R2
          next_st = dmwtc_pkg::ST_LOOK;
        end
      end
      dmwtc_pkg::ST_SNOOP:
      begin
        // Invalidate keeps tag and data, so parity stays consistent
        if (tag_match && e_valid)
        begin
          st_we = 1'b1; // R13
          wr_idx = dma_index;
          wr_tag = e_tag;
          wr_valid = 1'b0;
        end
        next_st = dmwtc_pkg::ST_IDLE;
      end
      dmwtc_pkg::ST_LOOK:
      begin
        next_last_hit = look_hit;
        if (!req_we && look_hit && !bypass)
        begin
          next_cpu_rdata = {e_hi, e_lo}; // R5
          next_cpu_hit = 1'b1;
          next_cpu_ack = 1'b1;
          next_st = dmwtc_pkg::ST_IDLE;
        end
        else
        begin
          next_st = dmwtc_pkg::ST_MEM; // R6 R9 R17
          next_alloc = !req_we && !force_miss && !bypass && !io_page; // R8 R15
          if (bypass && look_hit)
          begin
            st_we = 1'b1; // R16 R17
            wr_tag = e_tag;
            wr_valid = 1'b0;
          end
          else if (req_we && !force_miss && !bypass && !io_page && (!req_byte || look_hit))
          begin
            st_we = 1'b1; // R8 R9 R10
            if (!req_byte || !req_addr[dmwtc_pkg::A_BYTE])
            begin
              wr_lo = req_wdata[7:0];
            end
            if (!req_byte || req_addr[dmwtc_pkg::A_BYTE])
            begin
              wr_hi = req_wdata[15:8];
            end
          end
        end
      end
      dmwtc_pkg::ST_MEM:
      begin
        if (mem_ack)
        begin
          if (alloc)
          begin
            st_we = 1'b1; // R7 R8
            wr_hi = mem_rdata[15:8];
            wr_lo = mem_rdata[7:0];
          end
          next_cpu_rdata = req_we ? cpu_rdata : mem_rdata;
          next_cpu_hit = 1'b0;
          next_cpu_ack = 1'b1;
          next_alloc = 1'b0;
          next_st = dmwtc_pkg::ST_IDLE;
        end
      end
    endcase

    // Setters after clears: an event in the clearing cycle is kept
    if (st == dmwtc_pkg::ST_LOOK && bad_par)
    begin
      next_par_err = 1'b1;
    end
    if (dma_valid && dma_we)
    begin
      next_dma_pend = 1'b1; // R14 R20
      next_dma_addr_q = dma_addr;
    end
    if (reg_we && reg_addr == dmwtc_pkg::OFS_CCR && reg_wdata[dmwtc_pkg::CCR_FLUSH])
    begin
      next_flush_pend = 1'b1; // R18
    end
    if (reg_re && reg_addr == dmwtc_pkg::OFS_CCR)
    begin
      next_reg_rdata = cache_control_reg;
    end
    else if (reg_re && reg_addr == dmwtc_pkg::OFS_STAT)
    begin
      next_reg_rdata = {13'h0000, par_err, last_hit, st == dmwtc_pkg::ST_FLUSH};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st <= dmwtc_pkg::ST_FLUSH; // R12
      req_we <= 1'b0;
      req_byte <= 1'b0;
      req_addr <= 22'h000000;
      req_wdata <= 16'h0000;
      alloc <= 1'b0;
      cpu_ack <= 1'b0;
      cpu_hit <= 1'b0;
      cpu_rdata <= 16'h0000;
      dma_pend <= 1'b0;
      dma_addr_q <= 22'h000000;
      flush_pend <= 1'b0;
      flush_idx <= 12'h000;
      cache_control_reg <= dmwtc_pkg::CCR_RESET;
      last_hit <= 1'b0;
      par_err <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      st <= next_st;
      req_we <= next_req_we;
      req_byte <= next_req_byte;
      req_addr <= next_req_addr;
      req_wdata <= next_req_wdata;
      alloc <= next_alloc;
      cpu_ack <= next_cpu_ack;
      cpu_hit <= next_cpu_hit;
      cpu_rdata <= next_cpu_rdata;
      dma_pend <= next_dma_pend;
      dma_addr_q <= next_dma_addr_q;
      flush_pend <= next_flush_pend;
      flush_idx <= next_flush_idx;
      cache_control_reg <= next_ccr;
      last_hit <= next_last_hit;
      par_err <= next_par_err;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_look;
    st == dmwtc_pkg::ST_LOOK;
  endsequence

  sequence s_read_miss;
    s_look ##0 (!req_we && !look_hit);
  endsequence

  a_hit_qualified: assert property (s_look ##0 !(e_valid && tag_match && par_ok) // R4
    |=> !(cpu_ack && cpu_hit))
    else $error("hit without valid, tag match or good parity");
  a_read_hit_data: assert property (s_look ##0 (!req_we && look_hit && !bypass) |=> // R5
    cpu_ack && cpu_hit && cpu_rdata == $past({e_hi, e_lo}) && !mem_req)
    else $error("read hit did not return stored word");
  a_read_miss_mem: assert property (s_read_miss |=> mem_req && !mem_we) // R6
    else $error("read miss did not go to memory");
  a_alloc_entry: assert property (st == dmwtc_pkg::ST_MEM && mem_ack && alloc |-> // R7
    st_we && wr_entry[dmwtc_pkg::E_VALID] && wr_tag == req_label && {wr_hi, wr_lo} == mem_rdata)
    else $error("allocation wrote wrong entry");
  a_write_through: assert property (s_look ##0 req_we |=> mem_req && mem_we) // R9
    else $error("write not sent to memory");
  a_byte_miss_quiet: assert property (s_look ##0 (req_we && req_byte && !look_hit && !bypass) // R10
    |-> !st_we)
    else $error("byte write miss changed the store");
  a_io_never_hit: assert property (s_look ##0 io_page |-> !look_hit ##1 !alloc) // R11
    else $error("top page cached");
  a_reset_flush: assert property (!$past(rst_n) |-> st == dmwtc_pkg::ST_FLUSH) // R12
    else $error("no flush after reset");
  a_dma_inval: assert property (st == dmwtc_pkg::ST_SNOOP && tag_match && e_valid |-> // R13
    st_we && !wr_entry[dmwtc_pkg::E_VALID] && wr_idx == dma_index)
    else $error("dma write hit not invalidated");
  a_force_quiet: assert property (s_look ##0 force_miss |-> !st_we ##1 !alloc) // R15
    else $error("force miss touched the store");
  a_bypass_inval: assert property (s_look ##0 (bypass && look_hit) |-> // R16
    st_we && !wr_entry[dmwtc_pkg::E_VALID] ##1 mem_req)
    else $error("bypass hit not invalidated");
  a_flush_walk: assert property (st == dmwtc_pkg::ST_FLUSH |-> // R18
    st_we && !wr_entry[dmwtc_pkg::E_VALID] && wr_idx == flush_idx
    && wr_entry[dmwtc_pkg::E_TAG_PAR] == gen_tp && wr_entry[dmwtc_pkg::E_HI_PAR] == gen_hp
    && wr_entry[dmwtc_pkg::E_LO_PAR] == gen_lp)
    else $error("flush walk skipped an entry");

endmodule

`default_nettype wire

// >>> dmwtc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Main memory on the system bus, prompt or slow
// ------------------------------------------------------------------
module dmwtc_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [21:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  input wire logic dma_valid,
  input wire logic dma_we,
  input wire logic [21:0] dma_addr,
  input wire logic [15:0] dma_wdata
);
  logic [15:0] mm [int];
  logic [15:0] w;
  int wa;
  int wait_n;

  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    wait_n = 0;
  end

  // Read data toggles outside an answer so stale values never match
  always @(posedge ref_clk)
  begin
    if (dma_valid && dma_we)
      mm[int'(dma_addr[21:1])] = dma_wdata;
    wa = int'(mem_addr[21:1]);
    w = mm.exists(wa) ? mm[wa] : (16'(wa) ^ 16'h3c5a);
    if (mem_ack)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n = 0;
    end
    else if (mem_req && wait_n < (slow ? 4 : 0))
    begin
      wait_n++;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req)
    begin
      if (mem_we && !mem_byte)
        w = mem_wdata;
      else if (mem_we)
        w = mem_addr[0] ? {mem_wdata[15:8], w[7:0]} : {w[15:8], mem_wdata[7:0]};
      if (mem_we)
        mm[wa] = w;
      mem_rdata <= w;
      mem_ack <= 1'b1;
    end
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

`default_nettype wire

// >>> dmwtc_parity.sv
`timescale 1ns/1ns
`default_nettype none

// Parity over one field; ODD selects odd parity
module dmwtc_parity #(
  parameter int W = 8,
  parameter bit ODD = 1'b0
) (
  input wire logic [W-1:0] data,
  output logic par
);

  assign par = (^data) ^ ODD;

endmodule

`default_nettype wire

// >>> dmwtc_pkg.sv
package dmwtc_pkg;

  // ----------------------------------------------------------------
  // Address split and store geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int LABEL_W = 9;
  localparam int INDEX_W = 12;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ENTRIES = 4096;
  localparam int A_BYTE = 0;
  localparam int A_INDEX_LSB = 1;
  localparam int A_LABEL_LSB = 13;
  localparam logic [8:0] IO_LABEL = 9'h1ff;
  localparam logic [11:0] FLUSH_LAST = 12'hfff;

  // ----------------------------------------------------------------
  // Entry layout
  // ----------------------------------------------------------------
  localparam int ENTRY_W = 29;
  localparam int E_LO_PAR = 0;
  localparam int E_LO_LSB = 1;
  localparam int E_HI_PAR = 9;
  localparam int E_HI_LSB = 10;
  localparam int E_VALID = 18;
  localparam int E_TAG_PAR = 19;
  localparam int E_TAG_LSB = 20;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] OFS_CCR = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [15:0] CCR_RESET = 16'h0000;
  localparam logic [15:0] CCR_RW_MASK = 16'h06fd;
  localparam int CCR_FORCE_LO = 2;
  localparam int CCR_FORCE_HI = 3;
  localparam int CCR_WR_DPAR = 6;
  localparam int CCR_FLUSH = 8;
  localparam int CCR_BYPASS = 9;
  localparam int CCR_WR_TPAR = 10;
  localparam int ST_FLUSHING = 0;
  localparam int ST_LAST_HIT = 1;
  localparam int ST_PAR_ERR = 2;

  typedef enum logic [4:0] {
    ST_FLUSH = 5'h01,
    ST_IDLE = 5'h02,
    ST_LOOK = 5'h04,
    ST_SNOOP = 5'h08,
    ST_MEM = 5'h10
  } dmwtc_state_e;

endpackage

// >>> dmwtc_store.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Entry store, one registered read port and one write port
// ------------------------------------------------------------------
module dmwtc_store (
  input wire logic ref_clk,
  input wire logic [11:0] rd_idx,
  output logic [28:0] rd_entry,
  input wire logic wr_en,
  input wire logic [11:0] wr_idx,
  input wire logic [28:0] wr_entry
);

  // No reset: the flush walk initialises every entry
  logic [dmwtc_pkg::ENTRY_W-1:0] mem [0:dmwtc_pkg::ENTRIES-1];

  always_ff @(posedge ref_clk)
  begin
    rd_entry <= mem[rd_idx];
    if (wr_en)
    begin
      mem[wr_idx] <= wr_entry;
    end
  end

endmodule

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic cpu_byte = 1'b0;
  logic [21:0] cpu_addr = 22'h000000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic cpu_ack, cpu_hit, mem_req, mem_we, mem_byte, mem_ack;
  logic [15:0] cpu_rdata, mem_wdata, mem_rdata, reg_rdata;
  logic [21:0] mem_addr;
  logic dma_valid = 1'b0;
  logic dma_we = 1'b0;
  logic [21:0] dma_addr = 22'h000000;
  logic [15:0] dma_wdata = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic slow = 1'b0;
  bit m_val [4096];
  bit m_bad [4096];
  logic [8:0] m_tag [4096];
  logic [15:0] m_dat [4096];
  logic [15:0] mm [int];
  logic [15:0] ctl = 16'h0000;
  logic [31:0] seed = 32'h3fa8363c;
  int bad_count = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  dmwtc_cache DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_byte(cpu_byte), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .mem_req(mem_req), .mem_we(mem_we),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .dma_valid(dma_valid), .dma_we(dma_we), .dma_addr(dma_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));

  dmwtc_mem_model u_mem (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .dma_valid(dma_valid), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic bt, input logic sel,
    input logic [15:0] d);
    if (!bt)
      return d;
    return sel ? {d[15:8], o[7:0]} : {o[15:8], d[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Nothing is relied on until the flush walk is over
  task automatic wait_flush();
    logic [15:0] s;
    int n;
    n = 0;
    do
    begin
      reg_rd(dmwtc_pkg::OFS_STAT, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic set_ctrl(input logic [15:0] v);
    reg_wr(dmwtc_pkg::OFS_CCR, v);
    ctl = v & dmwtc_pkg::CCR_RW_MASK;
    if (v[8])
    begin
      m_val = '{default: 1'b0};
      wait_flush();
    end
  endtask

  // ----------------------------------------------------------------
  // Processor and DMA traffic against the reference model
  // ----------------------------------------------------------------
  task automatic cpu_op(input logic we, input logic bt, input logic [21:0] a, input logic [15:0] d);
    logic [11:0] ix;
    logic [15:0] ev, mw;
    logic look, h, frc;
    int wa, n;
    ix = a[12:1];
    wa = int'(a[21:1]);
    mw = mm.exists(wa) ? mm[wa] : (16'(wa) ^ 16'h3c5a);
    frc = ctl[2] | ctl[3];
    look = m_val[ix] && m_tag[ix] === a[21:13] && a[21:13] !== dmwtc_pkg::IO_LABEL;
    h = look && !m_bad[ix] && !frc;
    ev = (h && !ctl[9]) ? m_dat[ix] : mw;
    if (!frc && ctl[9] && h)
      m_val[ix] = 1'b0;
    else if (!frc && !ctl[9] && h && we)
    begin
      m_dat[ix] = merge(m_dat[ix], bt, a[0], d);
      m_bad[ix] = ctl[6] | ctl[10];
    end
    else if (!frc && !ctl[9] && !h && a[21:13] !== dmwtc_pkg::IO_LABEL && !(we && bt))
    begin
      m_val[ix] = 1'b1;
      m_tag[ix] = a[21:13];
      m_dat[ix] = we ? d : mw;
      m_bad[ix] = ctl[6] | ctl[10];
    end
    if (we)
      mm[wa] = merge(mw, bt, a[0], d);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_byte <= bt;
    cpu_addr <= a;
    cpu_wdata <= d;
    slow <= seed[7];
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    while (cpu_ack !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      bad_count++;
      close_out();
    end
    if (!we)
    begin
      chk("cpu_rdata", cpu_rdata, ev);
      chk("cpu_hit", {15'h0000, cpu_hit}, {15'h0000, h && !ctl[9]});
    end
    @(posedge ref_clk);
    cpu_req <= 1'b0;
  endtask

  task automatic dma(input logic we, input logic [21:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    dma_valid <= 1'b1;
    dma_we <= we;
    dma_addr <= a;
    dma_wdata <= d;
    @(posedge ref_clk);
    dma_valid <= 1'b0;
    repeat (5) @(posedge ref_clk);
    if (we && m_val[a[12:1]] && m_tag[a[12:1]] === a[21:13])
      m_val[a[12:1]] = 1'b0;
    if (we)
      mm[int'(a[21:1])] = d;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    logic [21:0] a;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(dmwtc_pkg::OFS_STAT, v);
    chk("flushing", {15'h0000, v[0]}, 16'h0001);
    reg_rd(dmwtc_pkg::OFS_CCR, v);
    chk("ctrl_reset", v, dmwtc_pkg::CCR_RESET);
    reg_rd(4'h8, v);
    chk("unmapped", v, 16'h0000);
    wait_flush();
    reg_wr(dmwtc_pkg::OFS_CCR, 16'hfeff);
    reg_rd(dmwtc_pkg::OFS_CCR, v);
    chk("ctrl", v, 16'hfeff & dmwtc_pkg::CCR_RW_MASK);
    set_ctrl(16'h0000);
    for (int k = 0; k < 80; k++)
    begin
      seed = lfsr(lfsr(seed));
      a = {(seed[10:8] == 3'h0) ? dmwtc_pkg::IO_LABEL : {8'h00, seed[4]}, 10'h000, seed[3:2],
        seed[0]};
      cpu_op(seed[5], seed[6], a, seed[31:16]);
    end
    a = {dmwtc_pkg::IO_LABEL, 12'h005, 1'b0};
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    a = 22'h000104;
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    dma(1'b1, a, 16'h1234);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    dma(1'b0, a, 16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    for (int k = 0; k < 3; k++)
      dma(1'b1, a + 22'(2 * k), 16'h4400 + 16'(k));
    for (int k = 0; k < 3; k++)
      cpu_op(1'b0, 1'b0, a + 22'(2 * k), 16'h0000);
    for (int b = 2; b < 4; b++)
    begin
      set_ctrl(16'h0001 << b);
      cpu_op(1'b1, 1'b0, a, 16'h7e00 + 16'(b));
      cpu_op(1'b0, 1'b0, a, 16'h0000);
      set_ctrl(16'h0000);
      cpu_op(1'b0, 1'b0, a, 16'h0000);
    end
    set_ctrl(16'h0200);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    set_ctrl(16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    // A fresh entry per pass, so each wrong-parity kind really gets written
    for (int k = 0; k < 2; k++)
    begin
      set_ctrl(k == 0 ? 16'h0040 : 16'h0400);
      cpu_op(1'b0, 1'b0, a + 22'h000200 + 22'(2 * k), 16'h0000);
      set_ctrl(16'h0000);
      cpu_op(1'b0, 1'b0, a + 22'h000200 + 22'(2 * k), 16'h0000);
      cpu_op(1'b0, 1'b0, a + 22'h000200 + 22'(2 * k), 16'h0000);
    end
    reg_rd(dmwtc_pkg::OFS_STAT, v);
    chk("par_err", {15'h0000, v[2]}, 16'h0001);
    reg_wr(dmwtc_pkg::OFS_STAT, 16'h0004);
    reg_rd(dmwtc_pkg::OFS_STAT, v);
    chk("par_err_clear", {15'h0000, v[2]}, 16'h0000);
    set_ctrl(16'h0100);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    set_ctrl(16'h0000);
    cpu_op(1'b0, 1'b0, a, 16'h0000);
    close_out();
  end
endmodule

`default_nettype wire
